// ==== lssl_pkg.sv ====
// Shared constants for the LED sink shift and latch control block
package lssl_pkg;
  localparam int CHAN_W = 16;
  localparam int STAT_W = 17;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] ONOFF_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] SINK_ADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] LIVE_ADDR = 8'h10;
  // Control register fields
  localparam int CTRL_FORCE_BLANK_BIT = 0;
  localparam int CTRL_RELOAD_PEND_BIT = 1;
  // Status word layout: overtemp in the top bit above sixteen open-LED flags
  localparam int STAT_OT_BIT = 16;
  // Reload word layout: overtemp replaces channel 15 open-LED flag
  localparam int RELOAD_OT_BIT = 15;
  // Reset values
  localparam logic [CHAN_W-1:0] CHAN_RESET = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RESET = 17'h0_0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic CTRL_FORCE_RESET = 1'b0;
endpackage : lssl_pkg

// ==== lssl_sync.sv ====
// Two flip-flop level synchroniser, one per bit
`timescale 1ns/100ps
module lssl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    stage1_q <= async_in;
    stage2_q <= stage1_q;
  end

  assign sync_out = stage2_q;
endmodule // lssl_sync

// ==== lssl_top.sv ====
// Serial on/off shift path, latches, blanking and APB access for 16 LED sinks
`timescale 1ns/100ps
// What this block does
// - Serial input enters shift register LSB
// - Each shift clock moves bits toward MSB
// - Latch strobe rise copies shift register out
// - Same edge requests a status reload, loaded into the shift register on the next shift clock
// - Blanking high forces every sink off
// - Blanking low drives sinks from latch while software blanking is clear
// - Blanking rise captures status into latch
// - Serial output shows shift register MSB
// - Serial output changes on shift clock or on a latch strobe rise (reload request)
module lssl_top
  import lssl_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic shift_clk_in,
  input wire logic serial_in,
  input wire logic latch_strobe_in,
  input wire logic blank_in,
  input wire logic [lssl_pkg::CHAN_W-1:0] open_led_flag_in,
  input wire logic overtemp_warning_flag_in,
  output logic serial_out,
  output logic [lssl_pkg::CHAN_W-1:0] sink_channel_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [lssl_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [lssl_pkg::DATA_W-1:0] pwdata_in,
  output logic [lssl_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  import lssl_pkg::*;

  logic latch_sync;
  logic blank_sync;
  logic latch_prev_q;
  logic blank_prev_q;
  logic latch_rise;
  logic blank_rise;
  logic link_reset_n;
  logic [CHAN_W-1:0] shift_q;
  logic reload_ack_q;
  logic reload_tgl_q;
  logic [CHAN_W-1:0] reload_word_q;
  logic reload_pend;
  logic [CHAN_W-1:0] onoff_q;
  logic [STAT_W-1:0] status_latch_q;
  logic [STAT_W-1:0] status_now;
  logic [CHAN_W-1:0] status_reload;
  logic force_blank_q;
  logic blank_eff;
  logic [CHAN_W-1:0] sink_q;
  logic [DATA_W-1:0] prdata_q;
  logic pslverr_q;
  logic [DATA_W-1:0] read_mux;
  logic addr_ok;
  logic setup_phase;
  logic access_phase;
  logic [STAT_W-1:0] flag_sync;
  logic ack_sync;
  logic reload_pend_sys;
  logic [CHAN_W-1:0] shift_view;

  // Pin levels pass two flip-flops before the system clock logic looks at them
  lssl_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk_in(clk_in),
    .async_in({latch_strobe_in, blank_in}),
    .sync_out({latch_sync, blank_sync})
  );

  // Reset carried into the link domain; needs two link clock edges
  lssl_sync #(
    .WIDTH(1)
  ) u_link_rst_sync (
    .clk_in(shift_clk_in),
    .async_in(reset_n_in),
    .sync_out(link_reset_n)
  );

  // Status flag pins are asynchronous levels; two flops before any use
  // each bit on its own, so a flag changing near a clock edge can split the status word
  lssl_sync #(
    .WIDTH(STAT_W)
  ) u_flag_sync (
    .clk_in(clk_in),
    .async_in({overtemp_warning_flag_in, open_led_flag_in}),
    .sync_out(flag_sync)
  );

  // Reload acknowledge brought back from the link domain
  lssl_sync #(
    .WIDTH(1)
  ) u_ack_sync (
    .clk_in(clk_in),
    .async_in(reload_ack_q),
    .sync_out(ack_sync)
  );

  // Edge detection on the synchronised strobes
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      latch_prev_q <= 1'b0;
      blank_prev_q <= 1'b0;
    end else begin
      latch_prev_q <= latch_sync;
      blank_prev_q <= blank_sync;
    end
  end

  assign latch_rise = latch_sync & ~latch_prev_q;
  assign blank_rise = blank_sync & ~blank_prev_q;

  // Live status: overtemp above the sixteen open-LED flags
  assign status_now = flag_sync;

  // Reload word: overtemp takes the slot of channel 15's open-LED flag
  assign status_reload = {flag_sync[STAT_OT_BIT], flag_sync[RELOAD_OT_BIT-1:0]};

  // Register as the system side sees it: a reload not yet shifted counts,
  // so a second strobe copies the status word into the control latch
  assign reload_pend_sys = reload_tgl_q ^ ack_sync;
  assign shift_view = reload_pend_sys ? reload_word_q : shift_q;

  // Control latch takes the settled shift word; the link clock is idle here
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      onoff_q <= CHAN_RESET;
    end else if (latch_rise) begin
      onoff_q <= shift_view;
    end
  end

  // Status reload request: word held steady, request flagged by a toggle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reload_word_q <= CHAN_RESET;
      reload_tgl_q <= 1'b0;
    end else if (latch_rise) begin
      reload_word_q <= status_reload;
      reload_tgl_q <= ~ack_sync;
    end
  end

  // Request outstanding until the link domain consumes it
  assign reload_pend = reload_tgl_q ^ reload_ack_q;

  // Shift register on the link clock; a pending reload replaces the old word
  // before the shift. Request and word are held steady for the guard time
  // after the strobe, so the link edge sees them settled.
  always_ff @(posedge shift_clk_in) begin
    if (!link_reset_n) begin
      shift_q <= CHAN_RESET;
      reload_ack_q <= 1'b0;
    end else if (reload_pend) begin
      shift_q <= {reload_word_q[CHAN_W-2:0], serial_in};
      reload_ack_q <= reload_tgl_q;
    end else begin
      shift_q <= {shift_q[CHAN_W-2:0], serial_in};
    end
  end

  // Cascade output: MSB of the register as the link side sees it
  assign serial_out = reload_pend ? reload_word_q[CHAN_W-1] : shift_q[CHAN_W-1];

  // Status latch captures flags on blanking rise
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      status_latch_q <= STAT_RESET;
    end else if (blank_rise) begin
      status_latch_q <= status_now;
    end
  end

  // Blanking from the pin or from software
  assign blank_eff = blank_sync | force_blank_q;

  // Sink enables, registered
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sink_q <= CHAN_RESET;
    end else if (blank_eff) begin
      sink_q <= CHAN_RESET;
    end else begin
      sink_q <= onoff_q;
    end
  end

  assign sink_channel_out = sink_q;

  // APB phases and decode
  assign setup_phase = psel_in & ~penable_in;
  assign access_phase = psel_in & penable_in;
  assign addr_ok = (paddr_in == CTRL_ADDR) || (paddr_in == ONOFF_ADDR) ||
                   (paddr_in == STATUS_ADDR) || (paddr_in == SINK_ADDR) ||
                   (paddr_in == LIVE_ADDR);

  // Read data selection
  always_comb begin
    read_mux = DATA_ZERO;
    case (paddr_in)
      CTRL_ADDR: begin
        read_mux[CTRL_FORCE_BLANK_BIT] = force_blank_q;
        read_mux[CTRL_RELOAD_PEND_BIT] = reload_pend_sys;
      end
      ONOFF_ADDR: read_mux[CHAN_W-1:0] = onoff_q;
      STATUS_ADDR: read_mux[STAT_W-1:0] = status_latch_q;
      SINK_ADDR: read_mux[CHAN_W-1:0] = sink_q;
      LIVE_ADDR: read_mux[STAT_W-1:0] = status_now;
      default: read_mux = DATA_ZERO;
    endcase
  end

  // Read data and error registered in the setup cycle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      prdata_q <= DATA_ZERO;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q <= pwrite_in ? DATA_ZERO : read_mux;
      pslverr_q <= ~addr_ok;
    end
  end

  // Software blanking control, written in the access cycle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      force_blank_q <= CTRL_FORCE_RESET;
    end else if (access_phase && pwrite_in && (paddr_in == CTRL_ADDR)) begin
      force_blank_q <= pwdata_in[CTRL_FORCE_BLANK_BIT];
    end
  end

  // Zero wait state slave
  assign pready_out = access_phase;
  assign prdata_out = prdata_q;
  assign pslverr_out = pslverr_q & access_phase;

  // Checks on the system clock
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_latch_copy;
    latch_rise |=> (onoff_q == $past(shift_view));
  endproperty
  a_latch_copy: assert property (p_latch_copy)
    else $error("control latch did not take the shift word");

  property p_reload_req;
    latch_rise |=> (reload_word_q == $past(status_reload)) && reload_pend_sys;
  endproperty
  a_reload_req: assert property (p_reload_req)
    else $error("status reload not requested on latch strobe");

  property p_blank_off;
    blank_eff |=> (sink_q == CHAN_RESET);
  endproperty
  a_blank_off: assert property (p_blank_off)
    else $error("sink on while blanked");

  property p_sink_follow;
    (!blank_eff && $stable(onoff_q)) [*2] |-> (sink_q == onoff_q);
  endproperty
  a_sink_follow: assert property (p_sink_follow)
    else $error("sink does not follow control latch");

  property p_status_cap;
    blank_rise |=> (status_latch_q == $past(status_now)) ##1 $stable(status_latch_q);
  endproperty
  a_status_cap: assert property (p_status_cap)
    else $error("status latch missed blanking rise");

  property p_out_stable;
    ($stable(shift_q) && $stable(reload_pend) && $stable(reload_word_q)) |-> $stable(serial_out);
  endproperty
  a_out_stable: assert property (p_out_stable)
    else $error("serial output moved without a shift or latch");

  property p_no_capture;
    !latch_rise |=> $stable(onoff_q);
  endproperty
  a_no_capture: assert property (p_no_capture)
    else $error("control latch changed without strobe");

  // Checks on the link clock
  property p_shift_in;
    @(posedge shift_clk_in) disable iff (!link_reset_n)
      1'b1 |=> (shift_q[0] == $past(serial_in));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial input not stored in LSB");

  property p_shift_move;
    @(posedge shift_clk_in) disable iff (!link_reset_n)
      !reload_pend |=> (shift_q[CHAN_W-1:1] == $past(shift_q[CHAN_W-2:0]));
  endproperty
  a_shift_move: assert property (p_shift_move)
    else $error("shift register did not move toward MSB");

  property p_out_msb;
    @(posedge shift_clk_in) disable iff (!link_reset_n)
      (!reload_pend ##1 !reload_pend) |-> (serial_out == $past(shift_q[CHAN_W-2]));
  endproperty
  a_out_msb: assert property (p_out_msb)
    else $error("serial output is not the shift MSB");

  // Sinks take exactly the blanked view of the latch one cycle later
  property p_sink_next;
    1'b1 |=> (sink_q == ($past(blank_eff) ? CHAN_RESET : $past(onoff_q)));
  endproperty
  a_sink_next: assert property (p_sink_next)
    else $error("sink enables differ from blanked latch view");

  // Status latch only moves on a blanking rise
  property p_status_hold;
    !blank_rise |=> $stable(status_latch_q);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status latch changed without blanking rise");

  // A strobe with a reload still pending copies the status word
  property p_latch_view;
    (latch_rise && reload_pend_sys) |=> (onoff_q == $past(reload_word_q));
  endproperty
  a_latch_view: assert property (p_latch_view)
    else $error("second strobe did not copy the reloaded word");

  // First link edge after a strobe shifts the reloaded status word
  property p_reload_shift;
    @(posedge shift_clk_in) disable iff (!link_reset_n)
      reload_pend |=> (shift_q[CHAN_W-1:1] == $past(reload_word_q[CHAN_W-2:0]));
  endproperty
  a_reload_shift: assert property (p_reload_shift)
    else $error("reload word not shifted on first link edge");

  // Scenario coverage
  c_latch: cover property (latch_rise);
  c_relatch: cover property (latch_rise && reload_pend_sys);
  c_blank: cover property (blank_rise);
  c_write: cover property (access_phase && pwrite_in && (paddr_in == CTRL_ADDR));
  c_reload: cover property (@(posedge shift_clk_in) reload_pend);
endmodule // lssl_top

// ==== lssl_ctrl_model.sv ====
// Behavioural display controller that shifts words in and strobes the latch
`timescale 1ns/100ps
module lssl_ctrl_model (
  input wire logic go_in,
  input wire logic [15:0] word_in,
  input wire logic [4:0] nbits_in,
  input wire logic latch_en_in,
  input wire logic cascade_in,
  output logic shift_clk_out,
  output logic serial_data_out,
  output logic latch_strobe_out,
  output logic busy_out,
  output logic [15:0] captured_out
);
  initial begin
    shift_clk_out = 1'b0;
    serial_data_out = 1'b0;
    latch_strobe_out = 1'b0;
    busy_out = 1'b0;
    captured_out = 16'h0000;
  end
  // One frame: MSB first at 64 ns, clock idle outside frames, then one strobe
  always @(posedge go_in) begin
    busy_out = 1'b1;
    for (int i = 0; i < nbits_in; i++) begin
      serial_data_out = word_in[15-i];
      #32;
      captured_out = {captured_out[14:0], cascade_in};
      shift_clk_out = 1'b1;
      #32;
      shift_clk_out = 1'b0;
    end
    serial_data_out = ~serial_data_out; // Released line shows no stale bit
    if (latch_en_in) begin
      #100 latch_strobe_out = 1'b1;
      #100 latch_strobe_out = 1'b0;
      #250;
    end
    busy_out = 1'b0;
  end
endmodule // lssl_ctrl_model

// ==== testbench.sv ====
// Self-checking bench for the LED sink shift and latch control block
`timescale 1ns/100ps
module testbench;
  import lssl_pkg::*;
  logic clk_in, reset_n_in, blank_in, overtemp_warning_flag_in, serial_out, shift_clk;
  logic serial_data, latch_strobe, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic go, latch_en, busy, so;
  logic [4:0] nbits;
  logic [CHAN_W-1:0] open_led_flag_in, sink_channel_out, word, captured;
  logic [ADDR_W-1:0] paddr_in;
  logic [DATA_W-1:0] pwdata_in, prdata_out, rd;
  logic err;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  lssl_top lssl_top_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .shift_clk_in(shift_clk),
    .serial_in(serial_data), .latch_strobe_in(latch_strobe), .blank_in(blank_in),
    .open_led_flag_in(open_led_flag_in), .overtemp_warning_flag_in(overtemp_warning_flag_in),
    .serial_out(serial_out), .sink_channel_out(sink_channel_out), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out));
  lssl_ctrl_model lssl_ctrl_model_i (.go_in(go), .word_in(word), .nbits_in(nbits),
    .latch_en_in(latch_en), .cascade_in(serial_out), .shift_clk_out(shift_clk),
    .serial_data_out(serial_data), .latch_strobe_out(latch_strobe), .busy_out(busy),
    .captured_out(captured));
  // System clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic frame(input logic [15:0] w, input logic [4:0] n, input logic le);
    word <= w;
    nbits <= n;
    latch_en <= le;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    @(posedge clk_in);
    while (busy !== 1'b0) @(posedge clk_in);
    repeat (6) @(posedge clk_in);
  endtask
  task automatic t_shift();
    frame(16'hA5C3, 5'd16, 1'b1);
    check("sinks", 32'(sink_channel_out), 32'h0000_A5C3);
    apb(1'b0, ONOFF_ADDR, DATA_ZERO);
    check("onoff", rd, 32'h0000_A5C3);
    frame(16'h1234, 5'd16, 1'b1);
    check("cascade", 32'(captured), 32'h0000_DA0F);
    check("sinks2", 32'(sink_channel_out), 32'h0000_1234);
    $display("shift test done");
  endtask
  task automatic t_blank();
    so = serial_out;
    blank_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    check("blanked", 32'(sink_channel_out), 32'h0000_0000);
    open_led_flag_in <= 16'h0001;
    apb(1'b0, STATUS_ADDR, DATA_ZERO);
    check("status", rd, 32'h0001_5A0F);
    apb(1'b0, LIVE_ADDR, DATA_ZERO);
    check("live", rd, 32'h0001_0001);
    blank_in <= 1'b0;
    open_led_flag_in <= 16'h5A0F;
    repeat (6) @(posedge clk_in);
    check("unblanked", 32'(sink_channel_out), 32'h0000_1234);
    check("cascade_hold", 32'(serial_out), 32'(so));
    $display("blank test done");
  endtask
  task automatic t_regs();
    frame(16'h0000, 5'd0, 1'b1);
    check("second_latch", 32'(sink_channel_out), 32'h0000_DA0F);
    apb(1'b0, CTRL_ADDR, DATA_ZERO);
    check("reload_pending", rd, 32'h0000_0002);
    apb(1'b0, 8'h14, DATA_ZERO);
    check("unmapped_err", 32'(err), 32'h0000_0001);
    check("unmapped_data", rd, 32'h0000_0000);
    apb(1'b1, ONOFF_ADDR, 32'h0000_FFFF);
    apb(1'b0, ONOFF_ADDR, DATA_ZERO);
    check("onoff_ro", rd, 32'h0000_DA0F);
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    repeat (6) @(posedge clk_in);
    check("force_blank", 32'(sink_channel_out), 32'h0000_0000);
    apb(1'b1, CTRL_ADDR, 32'h0000_0000);
    repeat (6) @(posedge clk_in);
    apb(1'b0, SINK_ADDR, DATA_ZERO);
    check("sink_reg", rd, 32'h0000_DA0F);
    $display("register test done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence: reset with link clock edges, then the scenarios
  initial begin
    reset_n_in = 1'b0;
    blank_in = 1'b0;
    open_led_flag_in = 16'h5A0F;
    overtemp_warning_flag_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0000_0000;
    go = 1'b0;
    word = 16'h0000;
    nbits = 5'd0;
    latch_en = 1'b0;
    fork
      frame(16'h0000, 5'd3, 1'b0);
      begin
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
      end
    join
    // Two link edges after release let the link side leave reset
    frame(16'h0000, 5'd2, 1'b0);
    repeat (3) @(posedge clk_in);
    check("reset_sinks", 32'(sink_channel_out), 32'h0000_0000);
    t_shift();
    t_blank();
    t_regs();
    complete_run();
  end
endmodule // testbench
